// [common/dacr_defs.vh]
// Summary of operation
// [R1] config [31:28] selects monitor output source
// [R2] config bit 12 enables fast trigger triggering
// [R3] config bit 11 adds trigger to readout
// [R4] software writes bits 8,4 one, reserved zero
// [R5] config bit 6 picks trigger edge
// [R6] config bit 3 substitutes sawtooth for samples
// [R7] primary offset write replaces, read returns word
// [R8] set alias sets ones, clear alias clears
// [R9] concurrent software should use set/clear aliases
// [R10] record length code selects samples per channel
// [R11] no length/rate writes while running
// [R12] sawtooth starts from test-wave start value
// [R13] rate code selects 5, 2.5, 1 GS/s
// [R14] control bit 5 picks full threshold
// [R15] control bit 3 picks trigger counting policy
// [R16] run bit start performs memory reset
// [R17] stopped keeps events, ignores triggers
// [R18] status bit 8 shows synchronized ready
// [R19] status bit 7 sticky low on unlock
// [R20] status bits 6,5 show bypass, clock source
// [R21] status bits 4,3 show full, event ready
// [R22] status bit 2 mirrors run state
// [R23] fast trigger compared against 16-bit threshold
// [R24] status writes and alias reads change nothing
`ifndef DACR_DEFS_VH
`define DACR_DEFS_VH
// ==========================================================
// register offsets
`define DACR_OFF_CFG 16'h8000
`define DACR_OFF_CFG_SET 16'h8004
`define DACR_OFF_CFG_CLR 16'h8008
`define DACR_OFF_BUF_LAYOUT 16'h800c
`define DACR_OFF_REC_LEN 16'h8020
`define DACR_OFF_TEST_START 16'h807c
`define DACR_OFF_RATE 16'h80d8
`define DACR_OFF_ACQ_CTRL 16'h8100
`define DACR_OFF_ACQ_STAT 16'h8104
`define DACR_OFF_THRESH 16'h8200
// ==========================================================
// field positions
`define DACR_CFG_MON_HI 31
`define DACR_CFG_MON_LO 28
`define DACR_CFG_TRG_EN 12
`define DACR_CFG_TRG_RD 11
`define DACR_CFG_POL 6
`define DACR_CFG_TEST 3
`define DACR_CTL_FULLMODE 5
`define DACR_CTL_CNTALL 3
`define DACR_CTL_RUN 2
// ==========================================================
// reset values
`define DACR_CFG_RST 32'h0000_0110
`define DACR_THRESH_RST 16'h0000
// ==========================================================
// monitor codes and buffer capacity
`define DACR_MON_NONE 4'h0
`define DACR_MON_ALL 4'h1
`define DACR_MON_ACC 4'h2
`define DACR_MON_BUSY 4'h3
`define DACR_NBUF 11'h400
// ==========================================================
// timing: memory reset pulse length in ns at 100 ns clock
`define DACR_MRST_NS 200
`define DACR_CLK_NS 100
`define DACR_MRST_CYC (`DACR_MRST_NS / `DACR_CLK_NS)
`endif

// [rtl/dacr_trig.v]
`timescale 1ns/1ns
`include "dacr_defs.vh"
// ==========================================================
// fast trigger front end: threshold compare and edge detect
module dacr_trig (
  input wire clk,
  input wire rst_n,
  input wire [15:0] level,
  input wire [15:0] threshold,
  input wire falling,
  output reg over_r,
  output wire edge_hit
);
  wire over_nxt;
  // compare against programmable threshold
  assign over_nxt = (level > threshold); // [R23]
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      over_r <= 1'b0;
    end else begin
      over_r <= over_nxt;
    end
  end
  // edge chosen by polarity bit
  assign edge_hit = falling ? (over_r & ~over_nxt) : (~over_r & over_nxt); // [R5]
endmodule // dacr_trig

// [rtl/dacr_regs.v]
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "dacr_defs.vh"
// ==========================================================
// acquisition configuration register bank, AXI4-Lite slave
module dacr_regs (
  input wire CORE_CLK,
  input wire RST_N,
  input wire [15:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [15:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire [15:0] FAST_TRIGGER_INPUT,
  input wire BUSY,
  input wire [11:0] ADC_SAMPLE,
  input wire EVENT_READ,
  input wire PLL_READY,
  input wire PLL_LOCKED,
  input wire PLL_BYPASS,
  input wire CLK_EXTERNAL,
  input wire BOARD_STATUS_READ,
  output reg MONITOR_OUT,
  output reg LOCAL_TRIGGER,
  output reg TRIGGER_IN_READOUT,
  output reg [11:0] SAMPLE_OUT,
  output reg [10:0] RECORD_SAMPLES,
  output reg [1:0] RATE_CODE,
  output reg MEMORY_RESET,
  output reg [31:0] TRIGGER_COUNT,
  output reg [10:0] EVENTS_STORED
);
  // ========================================================
  // register storage
  reg [31:0] cfg_r;
  reg [1:0] rec_len_r;
  reg [11:0] test_start_r;
  reg [1:0] rate_r;
  reg [5:0] ctrl_r;
  reg [15:0] thresh_r;
  reg lock_ok_r;
  reg [11:0] saw_r;
  reg [1:0] mrst_cnt_r;
  // write channel capture
  reg aw_have_r;
  reg w_have_r;
  reg [15:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  wire [31:0] wmask;
  wire wr_go;
  wire rd_go;
  wire run;
  wire trig_edge;
  wire full;
  wire accept;
  wire rd_hit;
  wire wr_hit;
  reg [31:0] rd_data;
  reg [10:0] rec_nxt;
  // pulse length is a plain integer; only its low bits load the counter
  wire [31:0] mrst_cyc;
  assign mrst_cyc = `DACR_MRST_CYC;
  assign run = ctrl_r[`DACR_CTL_RUN];
  // ========================================================
  // axi write path: address and data taken in either order
  assign S_AXI_AWREADY = ~aw_have_r & ~S_AXI_BVALID;
  assign S_AXI_WREADY = ~w_have_r & ~S_AXI_BVALID;
  assign wr_go = aw_have_r & w_have_r & ~S_AXI_BVALID;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_mask
      assign wmask[gi*8 +: 8] = {8{w_strb_r[gi]}};
    end
  endgenerate
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 16'h0000;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'b00;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_r <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_hit ? 2'b00 : 2'b10;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end
  // decode of writable offsets; status write is acknowledged but dropped
  assign wr_hit = (aw_addr_r == `DACR_OFF_CFG) || (aw_addr_r == `DACR_OFF_CFG_SET) ||
                  (aw_addr_r == `DACR_OFF_CFG_CLR) || (aw_addr_r == `DACR_OFF_BUF_LAYOUT) ||
                  (aw_addr_r == `DACR_OFF_REC_LEN) || (aw_addr_r == `DACR_OFF_TEST_START) ||
                  (aw_addr_r == `DACR_OFF_RATE) || (aw_addr_r == `DACR_OFF_ACQ_CTRL) ||
                  (aw_addr_r == `DACR_OFF_ACQ_STAT) || (aw_addr_r == `DACR_OFF_THRESH); // [R24]
  // ========================================================
  // register updates, byte strobes honoured
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_r <= `DACR_CFG_RST;
      rec_len_r <= 2'b00;
      test_start_r <= 12'h000;
      rate_r <= 2'b00;
      ctrl_r <= 6'h00;
      thresh_r <= `DACR_THRESH_RST;
    end else if (wr_go) begin
      case (aw_addr_r)
        `DACR_OFF_CFG: cfg_r <= (cfg_r & ~wmask) | (w_data_r & wmask); // [R7]
        `DACR_OFF_CFG_SET: cfg_r <= cfg_r | (w_data_r & wmask); // [R8]
        `DACR_OFF_CFG_CLR: cfg_r <= cfg_r & ~(w_data_r & wmask); // [R8]
        // software must not change these while running
        `DACR_OFF_REC_LEN: if (w_strb_r[0]) rec_len_r <= w_data_r[1:0]; // [R11]
        `DACR_OFF_RATE: if (w_strb_r[0]) rate_r <= w_data_r[1:0]; // [R11]
        `DACR_OFF_TEST_START: begin
          if (w_strb_r[0]) test_start_r[7:0] <= w_data_r[7:0];
          if (w_strb_r[1]) test_start_r[11:8] <= w_data_r[11:8];
        end
        `DACR_OFF_ACQ_CTRL: if (w_strb_r[0]) ctrl_r <= w_data_r[5:0] & 6'h2c;
        `DACR_OFF_THRESH: begin
          if (w_strb_r[0]) thresh_r[7:0] <= w_data_r[7:0];
          if (w_strb_r[1]) thresh_r[15:8] <= w_data_r[15:8];
        end
        default: cfg_r <= cfg_r;
      endcase
    end
  end
  // ========================================================
  // axi read path, one read at a time
  assign S_AXI_ARREADY = ~S_AXI_RVALID;
  assign rd_go = S_AXI_ARVALID & S_AXI_ARREADY;
  assign rd_hit = (S_AXI_ARADDR == `DACR_OFF_CFG) || (S_AXI_ARADDR == `DACR_OFF_CFG_SET) ||
                  (S_AXI_ARADDR == `DACR_OFF_CFG_CLR) || (S_AXI_ARADDR == `DACR_OFF_BUF_LAYOUT) ||
                  (S_AXI_ARADDR == `DACR_OFF_REC_LEN) || (S_AXI_ARADDR == `DACR_OFF_TEST_START) ||
                  (S_AXI_ARADDR == `DACR_OFF_RATE) || (S_AXI_ARADDR == `DACR_OFF_ACQ_CTRL) ||
                  (S_AXI_ARADDR == `DACR_OFF_ACQ_STAT) || (S_AXI_ARADDR == `DACR_OFF_THRESH);
  // read mux; aliases read zero and touch nothing
  always @* begin
    rd_data = 32'h0000_0000;
    case (S_AXI_ARADDR)
      `DACR_OFF_CFG: rd_data = cfg_r; // [R7]
      `DACR_OFF_REC_LEN: rd_data = {30'h0000_0000, rec_len_r};
      `DACR_OFF_TEST_START: rd_data = {20'h0_0000, test_start_r};
      `DACR_OFF_RATE: rd_data = {30'h0000_0000, rate_r};
      `DACR_OFF_ACQ_CTRL: rd_data = {26'h000_0000, ctrl_r};
      `DACR_OFF_THRESH: rd_data = {16'h0000, thresh_r};
      `DACR_OFF_ACQ_STAT: rd_data = {23'h00_0000, PLL_READY, lock_ok_r, PLL_BYPASS,
                                     CLK_EXTERNAL, full, (EVENTS_STORED != 11'h000),
                                     run, 2'b00}; // [R18] [R19] [R20] [R21] [R22]
      default: rd_data = 32'h0000_0000; // [R24]
    endcase
  end
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= 2'b00;
    end else if (rd_go) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_data;
      S_AXI_RRESP <= rd_hit ? 2'b00 : 2'b10;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end
  // ========================================================
  // pll lock flag: unlock wins over the restoring read
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lock_ok_r <= 1'b1;
    end else if (!PLL_LOCKED) begin
      lock_ok_r <= 1'b0; // [R19]
    end else if (BOARD_STATUS_READ) begin
      lock_ok_r <= 1'b1; // [R19]
    end
  end
  // ========================================================
  // fast trigger front end
  dacr_trig u_trig (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .level(FAST_TRIGGER_INPUT),
    .threshold(thresh_r),
    .falling(cfg_r[`DACR_CFG_POL]),
    .over_r(),
    .edge_hit(trig_edge)
  );
  // full threshold depends on keep-one-free mode
  assign full = ctrl_r[`DACR_CTL_FULLMODE] ? (EVENTS_STORED >= `DACR_NBUF - 11'h001)
                                           : (EVENTS_STORED >= `DACR_NBUF); // [R14] [R21]
  // stopped board neglects all triggers
  assign accept = trig_edge & cfg_r[`DACR_CFG_TRG_EN] & run & ~full & ~BUSY; // [R2] [R17]
  // ========================================================
  // trigger use, monitor, memory reset and event count
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      LOCAL_TRIGGER <= 1'b0;
      MONITOR_OUT <= 1'b0;
      TRIGGER_IN_READOUT <= 1'b0;
      TRIGGER_COUNT <= 32'h0000_0000;
      EVENTS_STORED <= 11'h000;
      MEMORY_RESET <= 1'b0;
      mrst_cnt_r <= 2'b00;
    end else begin
      LOCAL_TRIGGER <= accept;
      TRIGGER_IN_READOUT <= cfg_r[`DACR_CFG_TRG_RD]; // [R3]
      case (cfg_r[`DACR_CFG_MON_HI:`DACR_CFG_MON_LO])
        `DACR_MON_ALL: MONITOR_OUT <= trig_edge; // [R1]
        `DACR_MON_ACC: MONITOR_OUT <= accept; // [R1]
        `DACR_MON_BUSY: MONITOR_OUT <= BUSY; // [R1]
        default: MONITOR_OUT <= 1'b0; // [R1]
      endcase
      // run start clears the event memory for a fixed pulse
      if (wr_go && aw_addr_r == `DACR_OFF_ACQ_CTRL && w_strb_r[0] &&
          w_data_r[`DACR_CTL_RUN] && !run) begin
        mrst_cnt_r <= mrst_cyc[1:0]; // [R16]
        MEMORY_RESET <= 1'b1; // [R16]
        EVENTS_STORED <= 11'h000; // [R16]
        TRIGGER_COUNT <= 32'h0000_0000;
      end else begin
        if (mrst_cnt_r != 2'b00) begin
          mrst_cnt_r <= mrst_cnt_r - 2'b01;
        end
        MEMORY_RESET <= (mrst_cnt_r > 2'b01);
        // counting policy: all qualified edges or accepted only
        if (ctrl_r[`DACR_CTL_CNTALL] ? (trig_edge & run) : accept) begin
          TRIGGER_COUNT <= TRIGGER_COUNT + 32'h0000_0001; // [R15]
        end
        // events stay readable after stop
        if (accept && !EVENT_READ) begin
          EVENTS_STORED <= EVENTS_STORED + 11'h001; // [R17]
        end else if (!accept && EVENT_READ && EVENTS_STORED != 11'h000) begin
          EVENTS_STORED <= EVENTS_STORED - 11'h001;
        end
      end
    end
  end
  // ========================================================
  // record length and sample source
  always @* begin
    case (rec_len_r)
      2'b00: rec_nxt = 11'd1024; // [R10]
      2'b01: rec_nxt = 11'd520; // [R10]
      2'b10: rec_nxt = 11'd256; // [R10]
      default: rec_nxt = 11'd136; // [R10]
    endcase
  end
  // sawtooth restarts at start value whenever test mode is off
  always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      saw_r <= 12'h000;
      SAMPLE_OUT <= 12'h000;
      RECORD_SAMPLES <= 11'd1024;
      RATE_CODE <= 2'b00;
    end else begin
      RECORD_SAMPLES <= rec_nxt;
      RATE_CODE <= rate_r; // [R13]
      if (cfg_r[`DACR_CFG_TEST]) begin
        saw_r <= saw_r + 12'h001;
        SAMPLE_OUT <= saw_r; // [R6]
      end else begin
        saw_r <= test_start_r; // [R12]
        SAMPLE_OUT <= ADC_SAMPLE; // [R6]
      end
    end
  end
endmodule // dacr_regs

// [testbench/dacr_regs_chk.sv]
`timescale 1ns/1ns
// ==========================================================
// port-level checker for the configuration register bank
module dacr_regs_chk (
  input wire CORE_CLK,
  input wire RST_N,
  input wire [15:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  input wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire S_AXI_WVALID,
  input wire S_AXI_WREADY,
  input wire [1:0] S_AXI_BRESP,
  input wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [15:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire [1:0] S_AXI_RRESP,
  input wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire TRIGGER_IN_READOUT,
  input wire [10:0] RECORD_SAMPLES,
  input wire MEMORY_RESET
);
  // both write channels taken on one edge, as the bench always offers them
  wire wr_go = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  wire rd_go = S_AXI_ARVALID && S_AXI_ARREADY;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // ==========================================================
  // bus handshakes
  wr_resp_a: assert property (wr_go |-> ##2 S_AXI_BVALID)
    else $error("write response missing");
  b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");
  r_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped early");
  rd_resp_a: assert property (rd_go |=> S_AXI_RVALID)
    else $error("read response missing");
  busy_refuse_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while response pending");
  unmapped_rd_a: assert property (rd_go && S_AXI_ARADDR == 16'h9000
    |=> S_AXI_RRESP == 2'b10 && S_AXI_RDATA == 32'h0000_0000) else $error("unmapped read");
  // ==========================================================
  // configuration effects seen at the outputs
  cfg_set_a: assert property (wr_go && S_AXI_WDATA[11] &&
    (S_AXI_AWADDR == 16'h8000 || S_AXI_AWADDR == 16'h8004) |-> ##3 TRIGGER_IN_READOUT)
    else $error("readout enable not set");
  cfg_clr_a: assert property (wr_go && S_AXI_WDATA[11] && S_AXI_AWADDR == 16'h8008
    |-> ##3 !TRIGGER_IN_READOUT) else $error("readout enable not cleared");
  rec_len_a: assert property (wr_go && S_AXI_AWADDR == 16'h8020 && S_AXI_WDATA[1:0] == 2'b11
    |-> ##3 RECORD_SAMPLES == 11'h088) else $error("record length not 136");
  mrst_len_a: assert property ($rose(MEMORY_RESET) |=> MEMORY_RESET ##1 !MEMORY_RESET)
    else $error("memory reset pulse length");
  // main scenarios reached
  cover property (wr_go && S_AXI_AWADDR == 16'h8004);
  cover property ($rose(MEMORY_RESET));
  cover property (S_AXI_RVALID && S_AXI_RRESP == 2'b10);
endmodule // dacr_regs_chk

bind dacr_regs dacr_regs_chk u_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
  .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .TRIGGER_IN_READOUT(TRIGGER_IN_READOUT),
  .RECORD_SAMPLES(RECORD_SAMPLES), .MEMORY_RESET(MEMORY_RESET));

// [testbench/digitizer_acq_config_regs_tb_top.sv]
`timescale 1ns/1ns
module digitizer_acq_config_regs_tb_top;
  // ==========================================================
  // stimulus and observed signals
  logic clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, busy = 1'b0, ev_rd = 1'b0, bs_rd = 1'b0;
  logic pll_rdy = 1'b1, pll_lock = 1'b1, bypass = 1'b0, ext_clk = 1'b1;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000, lvl = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [11:0] adc = 12'h000;
  wire awready, wready, bvalid, arready, rvalid, mon, ltrig, trig_rd, mrst;
  wire [1:0] bresp, rresp, rate;
  wire [31:0] rdata, tcount;
  wire [11:0] smp;
  wire [10:0] recs, evs;
  logic [65:0] rq[$];
  logic [1:0] bq[$];
  integer fail_count = 0, tests_run = 0, seed = 51, i;
  logic [31:0] rv;
  int lens[4] = '{1024, 520, 256, 136};

  dacr_regs dut (.CORE_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .FAST_TRIGGER_INPUT(lvl), .BUSY(busy), .ADC_SAMPLE(adc), .EVENT_READ(ev_rd),
    .PLL_READY(pll_rdy), .PLL_LOCKED(pll_lock), .PLL_BYPASS(bypass), .CLK_EXTERNAL(ext_clk),
    .BOARD_STATUS_READ(bs_rd), .MONITOR_OUT(mon), .LOCAL_TRIGGER(ltrig),
    .TRIGGER_IN_READOUT(trig_rd), .SAMPLE_OUT(smp), .RECORD_SAMPLES(recs), .RATE_CODE(rate),
    .MEMORY_RESET(mrst), .TRIGGER_COUNT(tcount), .EVENTS_STORED(evs));

  initial begin
    forever #50 clk = ~clk;
  end
  // ==========================================================
  // compare, closing report and bus tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // address and data offered together, each released once taken
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r);
    integer n;
    @(posedge clk);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 20 && !bvalid; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (n == 20) begin
      fail_count++;
      conclude();
    end
  endtask
  // expected word is compared under a mask, the response code in full
  task automatic rd(input logic [15:0] a, input logic [31:0] e, m, input logic [1:0] r);
    integer n;
    @(posedge clk);
    rq.push_back({r, m, e});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 20 && !rvalid; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (n == 20) begin
      fail_count++;
      conclude();
    end
  endtask
  task automatic pause;
    @(posedge clk);
    #1;
  endtask
  // ==========================================================
  // response watcher: oldest note against each answer
  always @(posedge clk) begin
    if (rvalid && rready) begin
      chk("rdata", rq[0][31:0], rdata & rq[0][63:32]);
      chk("rresp", {30'h0, rq[0][65:64]}, {30'h0, rresp});
      void'(rq.pop_front());
    end
    if (bvalid && bready) begin
      chk("bresp", {30'h0, bq[0]}, {30'h0, bresp});
      void'(bq.pop_front());
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(16'h8000, 32'h0000_0110, 32'hffff_ffff, 2'b00);
    chk("record_samples", 32'd1024, {21'h0, recs});
    wr(16'h8000, 32'h3000_1918, 2'b00);
    rd(16'h8000, 32'h3000_1918, 32'hffff_ffff, 2'b00);
    chk("trig_readout", 32'h1, {31'h0, trig_rd});
    busy <= 1'b1;
    pause();
    pause();
    chk("monitor_busy", 32'h1, {31'h0, mon});
    @(posedge clk);
    busy <= 1'b0;
    pause();
    chk("monitor_idle", 32'h0, {31'h0, mon});
    wr(16'h8008, 32'h0000_0800, 2'b00);
    rd(16'h8000, 32'h3000_1118, 32'hffff_ffff, 2'b00);
    wr(16'h8004, 32'h0000_0800, 2'b00);
    rd(16'h8004, 32'h0000_0000, 32'hffff_ffff, 2'b00);
    rd(16'h8000, 32'h3000_1918, 32'hffff_ffff, 2'b00);
    $display("test configuration word done");
    for (i = 0; i < 4; i++) begin
      wr(16'h8020, i, 2'b00);
      pause();
      chk("record_samples", lens[i], {21'h0, recs});
    end
    rv = $unsigned($random(seed)) % 3;
    wr(16'h80d8, rv, 2'b00);
    rd(16'h80d8, rv, 32'h0000_0003, 2'b00);
    chk("rate_code", rv, {30'h0, rate});
    rv = $random(seed);
    adc <= rv[23:12];
    wr(16'h807c, rv, 2'b00);
    rd(16'h807c, rv & 32'h0000_0fff, 32'h0000_0fff, 2'b00);
    wr(16'h8008, 32'h0000_0008, 2'b00);
    #1;
    chk("adc_sample", {20'h0, rv[23:12]}, {20'h0, smp});
    wr(16'h8004, 32'h0000_0008, 2'b00);
    #1;
    chk("saw_start", {20'h0, rv[11:0]}, {20'h0, smp});
    rd(16'h9000, 32'h0000_0000, 32'hffff_ffff, 2'b10);
    $display("test length rate and wave done");
    wr(16'h8104, 32'hffff_ffff, 2'b00);
    rd(16'h8104, 32'h0000_01a0, 32'h0000_01fc, 2'b00);
    pll_lock <= 1'b0;
    @(posedge clk);
    pll_lock <= 1'b1;
    rd(16'h8104, 32'h0000_0000, 32'h0000_0080, 2'b00);
    bs_rd <= 1'b1;
    @(posedge clk);
    bs_rd <= 1'b0;
    rd(16'h8104, 32'h0000_0080, 32'h0000_0080, 2'b00);
    $display("test status done");
    wr(16'h8200, 32'h0000_1000, 2'b00);
    wr(16'h8100, 32'h0000_0004, 2'b00);
    rd(16'h8104, 32'h0000_0004, 32'h0000_0004, 2'b00);
    lvl <= 16'h2000;
    for (i = 0; i < 20 && tcount !== 32'h1; i++) @(posedge clk);
    if (i == 20) begin
      fail_count++;
      conclude();
    end
    chk("trigger_count", 32'h1, tcount);
    rd(16'h8104, 32'h0000_0008, 32'h0000_0008, 2'b00);
    lvl <= 16'h0000;
    wr(16'h8100, 32'h0000_0000, 2'b00);
    lvl <= 16'h2000;
    repeat (5) @(posedge clk);
    chk("stopped_count", 32'h1, tcount);
    rd(16'h8104, 32'h0000_0008, 32'h0000_000c, 2'b00);
    $display("test run and stop done");
    wr(16'h8008, 32'h0000_1000, 2'b00);
    wr(16'h8100, 32'h0000_000c, 2'b00);
    chk("events_cleared", 32'h0, {21'h0, evs});
    lvl <= 16'h0000;
    @(posedge clk);
    lvl <= 16'h2000;
    repeat (3) @(posedge clk);
    chk("count_all", 32'h1, tcount);
    chk("unaccepted", 32'h0, {21'h0, evs});
    wr(16'h8004, 32'h0000_0040, 2'b00);
    lvl <= 16'h0000;
    repeat (3) @(posedge clk);
    chk("falling_count", 32'h2, tcount);
    lvl <= 16'h2000;
    repeat (3) @(posedge clk);
    chk("rising_ignored", 32'h2, tcount);
    $display("test counting and polarity done");
    wr(16'h8004, 32'h0000_1000, 2'b00);
    wr(16'h8100, 32'h0000_0024, 2'b00);
    rv = 32'h0000_0000;
    for (i = 0; i < 2100; i++) begin
      @(posedge clk);
      if (ltrig === 1'b1) rv = rv + 32'h0000_0001;
      lvl <= lvl ^ 16'h2000;
    end
    chk("local_triggers", 32'd1023, rv);
    chk("full_keep_one", 32'd1023, {21'h0, evs});
    rd(16'h8104, 32'h0000_0018, 32'h0000_0018, 2'b00);
    wr(16'h8100, 32'h0000_0004, 2'b00);
    for (i = 0; i < 10; i++) begin
      @(posedge clk);
      lvl <= lvl ^ 16'h2000;
    end
    chk("full_normal", 32'd1024, {21'h0, evs});
    rd(16'h8104, 32'h0000_0018, 32'h0000_0018, 2'b00);
    $display("test full threshold done");
    conclude();
  end
endmodule // digitizer_acq_config_regs_tb_top
